// ---- csrs_alu_flags.v ----
`timescale 1ns/10ps
`include "csrs_regs.vh"
// ==========================================================
// Arithmetic unit with flag results.
module csrs_alu_flags (
  input wire [2:0] op_i,
  input wire [7:0] acc_i,
  input wire [7:0] opnd_i,
  input wire carry_i,
  output reg [7:0] acc_o,
  output reg [7:0] opnd_o,
  output reg carry_o,
  output reg half_o,
  output reg ovf_o
);
  reg [8:0] sum;
  reg [4:0] nib;
  reg [15:0] prod;
  reg cin;
  // Flags follow each operation; division by zero leaves operands as they were.
  always @* begin
    sum = 9'h000;
    nib = 5'h00;
    prod = 16'h0000;
    cin = 1'b0;
    acc_o = acc_i;
    opnd_o = opnd_i;
    carry_o = 1'b0;
    half_o = 1'b0;
    ovf_o = 1'b0;
    case (op_i)
      `CSRS_OP_ADD, `CSRS_OP_ADDC: begin
        cin = (op_i == `CSRS_OP_ADDC) ? carry_i : 1'b0;
        sum = {1'b0, acc_i} + {1'b0, opnd_i} + {8'h00, cin};
        nib = {1'b0, acc_i[3:0]} + {1'b0, opnd_i[3:0]} + {4'h0, cin};
        acc_o = sum[7:0];
        carry_o = sum[8]; // RQ4
        half_o = nib[4]; // RQ5
        ovf_o = (acc_i[7] == opnd_i[7]) && (sum[7] != acc_i[7]); // RQ8
      end
      `CSRS_OP_SUBB: begin
        sum = {1'b0, acc_i} - {1'b0, opnd_i} - {8'h00, carry_i};
        nib = {1'b0, acc_i[3:0]} - {1'b0, opnd_i[3:0]} - {4'h0, carry_i};
        acc_o = sum[7:0];
        carry_o = sum[8]; // RQ4
        half_o = nib[4]; // RQ5
        ovf_o = (acc_i[7] != opnd_i[7]) && (sum[7] != acc_i[7]); // RQ8
      end
      `CSRS_OP_MUL: begin
        prod = acc_i * opnd_i; // RQ13
        acc_o = prod[7:0];
        opnd_o = prod[15:8];
        ovf_o = (prod[15:8] != 8'h00); // RQ9
      end
      `CSRS_OP_DIV: begin
        if (opnd_i == 8'h00) begin
          ovf_o = 1'b1; // RQ10
        end else begin
          acc_o = acc_i / opnd_i; // RQ13
          opnd_o = acc_i % opnd_i;
        end
      end
      default: begin
        acc_o = acc_i;
      end
    endcase
  end
endmodule

// ---- csrs_bit_merge.v ----
`timescale 1ns/10ps
// ==========================================================
// Byte or single-bit write merge for bit-addressable registers.
module csrs_bit_merge (
  input wire [7:0] old_i,
  input wire [7:0] wdata_i,
  input wire bit_mode_i,
  input wire [2:0] bit_sel_i,
  output reg [7:0] new_o
);
  // A bit write changes only the selected bit, from wdata bit 0.
  always @* begin
    new_o = wdata_i;
    if (bit_mode_i) begin
      new_o = old_i;
      new_o[bit_sel_i] = wdata_i[0]; // RQ15
    end
  end
endmodule

// ---- csrs_core.v ----
`timescale 1ns/10ps
`include "csrs_regs.vh"
// Behaviour
// RQ1: After reset the stack top index holds 0x07.
// RQ2: Each push first adds one to the stack top index, then writes at the new index.
// RQ3: The two pointer bytes join into one 16-bit indirect address.
// RQ4: Carry is set on an add carry or subtract borrow and cleared by other arithmetic.
// RQ5: Half carry is set on a carry into or borrow from the upper nibble, else cleared.
// RQ6: Status bits 5 and 1 are user flags that only software changes.
// RQ7: Status bits 4 and 3 pick one of four eight-byte register banks upward from 0x00.
// RQ8: Overflow is set on signed overflow of add, add with carry or subtract with borrow.
// RQ9: Overflow is set when a multiply product exceeds 255.
// RQ10: Overflow is set when a divide has a zero divisor.
// RQ11: Those five operations clear overflow when their condition is absent.
// RQ12: Status bit 0 is read-only and shows odd parity of the accumulator.
// RQ13: The second operand register supplies and receives multiply and divide operands.
// RQ14: Software keeps reserved bits at zero and new features reset to zero.
// RQ15: Registers at addresses ending in 0 or 8 accept bit as well as byte accesses.
// RQ16: Parity is recomputed from the accumulator each cycle.
module csrs_core (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire sfr_wr_i,
  input wire sfr_rd_i,
  input wire [7:0] sfr_addr_i,
  input wire [7:0] sfr_wdata_i,
  input wire sfr_bit_i,
  input wire [2:0] sfr_bit_sel_i,
  input wire alu_go_i,
  input wire [2:0] alu_op_i,
  input wire acc_ld_i,
  input wire [7:0] acc_ld_data_i,
  input wire push_i,
  input wire pop_i,
  input wire ptr_ld_i,
  input wire [15:0] ptr_ld_data_i,
  input wire ptr_inc_i,
  input wire [2:0] reg_num_i,
  output reg [7:0] sfr_rdata_o,
  output reg sfr_hit_o,
  output reg [7:0] stack_top_index_o,
  output reg [7:0] push_addr_o,
  output reg push_we_o,
  output reg [15:0] indirect_pointer_word_o,
  output reg [7:0] primary_accumulator_o,
  output reg [7:0] secondary_operand_o,
  output reg [7:0] program_status_word_o,
  output reg [7:0] bank_reg_addr_o
);
  // ========================================================
  // State registers.
  // Each architectural register has a _reg and the value it takes at the next edge.
  reg [7:0] stack_top_index_reg;
  reg [7:0] stack_top_index_next;
  reg [7:0] pointer_low_byte_reg;
  reg [7:0] pointer_low_byte_next;
  reg [7:0] pointer_high_byte_reg;
  reg [7:0] pointer_high_byte_next;
  reg [7:0] acc_reg;
  reg [7:0] acc_next;
  reg [7:0] opnd_reg;
  reg [7:0] opnd_next;
  reg carry_flag_reg;
  reg carry_flag_next;
  reg half_carry_flag_reg;
  reg half_carry_flag_next;
  reg user_flag_a_reg;
  reg user_flag_a_next;
  reg user_flag_b_reg;
  reg user_flag_b_next;
  reg [1:0] bank_sel_reg;
  reg [1:0] bank_sel_next;
  reg overflow_flag_reg;
  reg overflow_flag_next;
  // Arithmetic unit results, kept only when alu_go_i asks for them.
  wire [7:0] alu_acc;
  wire [7:0] alu_opnd;
  wire alu_carry;
  wire alu_half;
  wire alu_ovf;
  // Write merge, live status word and pointer helpers.
  wire [7:0] merged;
  wire parity;
  wire [7:0] status_now;
  wire [7:0] merge_old;
  wire [15:0] ptr_plus;

  // Odd parity over the accumulator; purely combinational so it never lags a write.
  function par8;
    input [7:0] v;
    begin
      par8 = ^v;
    end
  endfunction

  // Only the addresses with low nibble 0 or 8 allow single-bit writes.
  function bit_ok;
    input [7:0] a;
    begin
      bit_ok = (a[2:0] == 3'h0);
    end
  endfunction

  // Index of the slot a push fills. Shared by the index update and the push address,
  // so the two agree unless a bus write replaces the index in the same cycle.
  function [7:0] idx_up;
    input [7:0] v;
    begin
      idx_up = v + 8'h01;
    end
  endfunction

  // Packs the status fields into their byte positions, parity in bit 0.
  function [7:0] pack_status;
    input cy;
    input ac;
    input ua;
    input [1:0] bank;
    input ov;
    input ub;
    input par;
    begin
      pack_status = {cy, ac, ua, bank, ov, ub, par};
    end
  endfunction

  // Live status word as software reads it; parity never waits for a clock edge.
  assign parity = par8(acc_reg); // RQ16
  assign status_now = pack_status(carry_flag_reg, half_carry_flag_reg, user_flag_a_reg,
                                  bank_sel_reg, overflow_flag_reg, user_flag_b_reg, parity);
  assign merge_old = (sfr_addr_i == `CSRS_ADDR_ACC) ? acc_reg :
                     (sfr_addr_i == `CSRS_ADDR_OPND) ? opnd_reg : status_now;
  assign ptr_plus = {pointer_high_byte_reg, pointer_low_byte_reg} + 16'h0001;

  // The arithmetic unit always works on the current registers.
  csrs_alu_flags u_alu (
    .op_i(alu_op_i),
    .acc_i(acc_reg),
    .opnd_i(opnd_reg),
    .carry_i(carry_flag_reg),
    .acc_o(alu_acc),
    .opnd_o(alu_opnd),
    .carry_o(alu_carry),
    .half_o(alu_half),
    .ovf_o(alu_ovf)
  );

  // Bit writes are honoured only at bit-addressable addresses; elsewhere a byte is written.
  csrs_bit_merge u_merge (
    .old_i(merge_old),
    .wdata_i(sfr_wdata_i),
    .bit_mode_i(sfr_bit_i && bit_ok(sfr_addr_i)),
    .bit_sel_i(sfr_bit_sel_i),
    .new_o(merged)
  );

  // ========================================================
  // Next-state logic. Datapath actions come first; a register bus write in the
  // same cycle wins, since software intent is the later instruction effect.
  always @* begin
    stack_top_index_next = stack_top_index_reg;
    pointer_low_byte_next = pointer_low_byte_reg;
    pointer_high_byte_next = pointer_high_byte_reg;
    acc_next = acc_reg;
    opnd_next = opnd_reg;
    carry_flag_next = carry_flag_reg;
    half_carry_flag_next = half_carry_flag_reg;
    user_flag_a_next = user_flag_a_reg;
    user_flag_b_next = user_flag_b_reg;
    bank_sel_next = bank_sel_reg;
    overflow_flag_next = overflow_flag_reg;
    // Stack index: a push moves it up first, a pop moves it down; push wins.
    if (push_i) begin
      stack_top_index_next = idx_up(stack_top_index_reg); // RQ2
    end else if (pop_i) begin
      stack_top_index_next = stack_top_index_reg - 8'h01;
    end
    // Pointer word: a load beats an increment; the increment carries into the high byte.
    // Wrap-around from the top address back to zero is silent.
    if (ptr_ld_i) begin
      pointer_high_byte_next = ptr_ld_data_i[15:8]; // RQ3
      pointer_low_byte_next = ptr_ld_data_i[7:0];
    end else if (ptr_inc_i) begin
      pointer_high_byte_next = ptr_plus[15:8]; // RQ3
      pointer_low_byte_next = ptr_plus[7:0];
    end
    // Arithmetic beats a datapath accumulator load issued in the same cycle.
    if (alu_go_i && (alu_op_i != `CSRS_OP_OTHER)) begin
      // A divide by zero hands back the old operands, so both stay as they were.
      acc_next = alu_acc;
      opnd_next = alu_opnd; // RQ13
      if (alu_op_i != `CSRS_OP_MUL && alu_op_i != `CSRS_OP_DIV) begin
        carry_flag_next = alu_carry; // RQ4
        half_carry_flag_next = alu_half; // RQ5
      end else begin
        carry_flag_next = 1'b0; // RQ4
        half_carry_flag_next = 1'b0; // RQ5
      end
      overflow_flag_next = alu_ovf; // RQ11
    end else if (acc_ld_i) begin
      acc_next = acc_ld_data_i;
    end
    // User flags and bank select are touched only by the register bus below.
    if (sfr_wr_i) begin
      case (sfr_addr_i)
        `CSRS_ADDR_STACK: begin
          // A bus write to the index replaces any push or pop of the same cycle.
          stack_top_index_next = sfr_wdata_i;
        end
        `CSRS_ADDR_PTR_LO: begin
          pointer_low_byte_next = sfr_wdata_i;
        end
        `CSRS_ADDR_PTR_HI: begin
          pointer_high_byte_next = sfr_wdata_i;
        end
        `CSRS_ADDR_ACC: begin
          // A bit write keeps the other seven accumulator bits.
          acc_next = merged; // RQ15
        end
        `CSRS_ADDR_OPND: begin
          opnd_next = merged; // RQ15
        end
        `CSRS_ADDR_STATUS: begin
          carry_flag_next = merged[`CSRS_BIT_CARRY];
          half_carry_flag_next = merged[`CSRS_BIT_HALF];
          user_flag_a_next = merged[`CSRS_BIT_USER_A]; // RQ6
          bank_sel_next = merged[`CSRS_BIT_BANK_HI:`CSRS_BIT_BANK_LO]; // RQ7
          overflow_flag_next = merged[`CSRS_BIT_OVF];
          user_flag_b_next = merged[`CSRS_BIT_USER_B]; // RQ6
          // Parity bit ignores writes; it is always derived from the accumulator.
        end
        default: begin
          // Reserved and foreign addresses leave every register alone.
        end
      endcase
    end
  end

  // ========================================================
  // Register update with synchronous reset.
  // One edge with rstn_i low is enough; every register takes its reset value.
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      stack_top_index_reg <= `CSRS_RST_STACK; // RQ1
      pointer_low_byte_reg <= `CSRS_RST_PTR_LO;
      pointer_high_byte_reg <= `CSRS_RST_PTR_HI;
      acc_reg <= `CSRS_RST_ACC;
      opnd_reg <= `CSRS_RST_OPND;
      carry_flag_reg <= 1'b0;
      half_carry_flag_reg <= 1'b0;
      user_flag_a_reg <= 1'b0;
      user_flag_b_reg <= 1'b0;
      bank_sel_reg <= 2'h0;
      overflow_flag_reg <= 1'b0;
    end else begin
      stack_top_index_reg <= stack_top_index_next;
      pointer_low_byte_reg <= pointer_low_byte_next;
      pointer_high_byte_reg <= pointer_high_byte_next;
      acc_reg <= acc_next;
      opnd_reg <= opnd_next;
      carry_flag_reg <= carry_flag_next;
      half_carry_flag_reg <= half_carry_flag_next;
      user_flag_a_reg <= user_flag_a_next;
      user_flag_b_reg <= user_flag_b_next;
      bank_sel_reg <= bank_sel_next;
      overflow_flag_reg <= overflow_flag_next;
    end
  end

  // ========================================================
  // Read port. Data and hit stand for one cycle after the strobe and are zero
  // otherwise, so a bus that ORs several slaves together needs no extra gating.
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      sfr_rdata_o <= 8'h00;
      sfr_hit_o <= 1'b0;
    end else begin
      sfr_hit_o <= 1'b0;
      sfr_rdata_o <= 8'h00;
      if (sfr_rd_i) begin
        sfr_hit_o <= 1'b1;
        case (sfr_addr_i)
          `CSRS_ADDR_STACK: begin
            sfr_rdata_o <= stack_top_index_reg;
          end
          `CSRS_ADDR_PTR_LO: begin
            sfr_rdata_o <= pointer_low_byte_reg;
          end
          `CSRS_ADDR_PTR_HI: begin
            sfr_rdata_o <= pointer_high_byte_reg;
          end
          `CSRS_ADDR_STATUS: begin
            sfr_rdata_o <= status_now; // RQ12
          end
          `CSRS_ADDR_ACC: begin
            sfr_rdata_o <= acc_reg;
          end
          `CSRS_ADDR_OPND: begin
            sfr_rdata_o <= opnd_reg;
          end
          default: begin
            // Reserved addresses answer with no hit and zero data.
            sfr_hit_o <= 1'b0;
          end
        endcase
      end
    end
  end

  // ========================================================
  // Push port. The address is the index after the increment, so the byte lands one
  // above the old top; a bus write to the index in the same cycle is not reflected here.
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      push_addr_o <= 8'h00;
      push_we_o <= 1'b0;
    end else begin
      push_we_o <= push_i;
      push_addr_o <= idx_up(stack_top_index_reg); // RQ2
    end
  end

  // ========================================================
  // Mirror outputs. They are loaded from next-state values, so they change on the
  // same edge as the registers they copy; parity comes from the next accumulator.
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      stack_top_index_o <= `CSRS_RST_STACK;
      indirect_pointer_word_o <= 16'h0000;
      primary_accumulator_o <= `CSRS_RST_ACC;
      secondary_operand_o <= `CSRS_RST_OPND;
      program_status_word_o <= `CSRS_RST_STATUS;
      bank_reg_addr_o <= 8'h00;
    end else begin
      stack_top_index_o <= stack_top_index_next;
      indirect_pointer_word_o <= {pointer_high_byte_next, pointer_low_byte_next}; // RQ3
      primary_accumulator_o <= acc_next;
      secondary_operand_o <= opnd_next;
      program_status_word_o <= pack_status(carry_flag_next, half_carry_flag_next,
                                           user_flag_a_next, bank_sel_next,
                                           overflow_flag_next, user_flag_b_next,
                                           par8(acc_next)); // RQ12
      bank_reg_addr_o <= {3'h0, bank_sel_next, reg_num_i}; // RQ7
    end
  end
endmodule

// ---- csrs_core_sva.sv ----
`timescale 1ns/10ps
`include "csrs_regs.vh"
// ====================
// Port checks.
module csrs_core_chk (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire sfr_wr_i,
  input wire alu_go_i,
  input wire [2:0] alu_op_i,
  input wire push_i,
  input wire [7:0] sfr_addr_i,
  input wire ptr_ld_i,
  input wire [15:0] ptr_ld_data_i,
  input wire [2:0] reg_num_i,
  input wire [7:0] stack_top_index_o,
  input wire [7:0] push_addr_o,
  input wire push_we_o,
  input wire [15:0] indirect_pointer_word_o,
  input wire [7:0] primary_accumulator_o,
  input wire [7:0] secondary_operand_o,
  input wire [7:0] program_status_word_o,
  input wire [7:0] bank_reg_addr_o
);
  // Short aliases; a bus write in the same cycle overrides the datapath.
  wire [7:0] acc = primary_accumulator_o;
  wire [7:0] opd = secondary_operand_o;
  wire [7:0] program_status_word = program_status_word_o;
  wire alu = alu_go_i && !sfr_wr_i;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  // Reset is synchronous, so its own check must not be disabled by it.
  reset_index_a: assert property (disable iff (1'b0)
    !rstn_i |=> stack_top_index_o == 8'h07) else $error("stack index not 07 after reset");
  push_index_a: assert property (push_i && !(sfr_wr_i && sfr_addr_i == 8'h81) |=>
    stack_top_index_o == $past(stack_top_index_o) + 8'h01 && push_we_o
    && push_addr_o == stack_top_index_o) else $error("push index wrong");
  pointer_load_a: assert property (ptr_ld_i && !sfr_wr_i |=>
    indirect_pointer_word_o == $past(ptr_ld_data_i)) else $error("pointer word wrong");
  add_flags_a: assert property (alu && alu_op_i == `CSRS_OP_ADD |=>
    {program_status_word[7], acc} == {1'b0, $past(acc)} + $past(opd)
    && program_status_word[6] == ($past(acc[3:0]) + $past(opd[3:0]) > 15)
    && program_status_word[2] == ($past(acc[7]) == $past(opd[7]) && acc[7] != $past(acc[7])))
    else $error("add result or flags wrong");
  mul_ovf_a: assert property (alu && alu_op_i == `CSRS_OP_MUL |=>
    {opd, acc} == $past(acc) * $past(opd) && program_status_word[2] == ({opd, acc} > 255))
    else $error("multiply result or overflow wrong");
  div_zero_a: assert property (alu && alu_op_i == `CSRS_OP_DIV && opd == 8'h00 |=>
    program_status_word[2] && $stable(acc) && $stable(opd)) else $error("divide by zero mishandled");
  user_flags_a: assert property (alu |=> program_status_word[5:3] == $past(program_status_word[5:3]) &&
    program_status_word[1] == $past(program_status_word[1])) else $error("alu changed user or bank bits");
  parity_live_a: assert property (program_status_word[0] == ^acc)
    else $error("parity bit wrong");
  bank_addr_a: assert property ($past(rstn_i) |->
    bank_reg_addr_o == {3'h0, program_status_word[4:3], $past(reg_num_i)}) else $error("bank address wrong");
endmodule

bind csrs_core csrs_core_chk chk_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
  .sfr_wr_i(sfr_wr_i), .alu_go_i(alu_go_i), .alu_op_i(alu_op_i), .push_i(push_i),
  .sfr_addr_i(sfr_addr_i), .ptr_ld_i(ptr_ld_i), .ptr_ld_data_i(ptr_ld_data_i),
  .reg_num_i(reg_num_i), .stack_top_index_o(stack_top_index_o), .push_addr_o(push_addr_o),
  .push_we_o(push_we_o), .indirect_pointer_word_o(indirect_pointer_word_o),
  .primary_accumulator_o(primary_accumulator_o), .secondary_operand_o(secondary_operand_o),
  .program_status_word_o(program_status_word_o), .bank_reg_addr_o(bank_reg_addr_o));

// ---- csrs_regs.vh ----
`ifndef CSRS_REGS_VH
`define CSRS_REGS_VH
// ==========================================================
// Special register addresses.
`define CSRS_ADDR_STACK 8'h81
`define CSRS_ADDR_PTR_LO 8'h82
`define CSRS_ADDR_PTR_HI 8'h83
`define CSRS_ADDR_STATUS 8'hD0
`define CSRS_ADDR_ACC 8'hE0
`define CSRS_ADDR_OPND 8'hF0
// ==========================================================
// Reset values.
`define CSRS_RST_STACK 8'h07
`define CSRS_RST_PTR_LO 8'h00
`define CSRS_RST_PTR_HI 8'h00
`define CSRS_RST_STATUS 8'h00
`define CSRS_RST_ACC 8'h00
`define CSRS_RST_OPND 8'h00
// ==========================================================
// Status word field positions.
`define CSRS_BIT_CARRY 7
`define CSRS_BIT_HALF 6
`define CSRS_BIT_USER_A 5
`define CSRS_BIT_BANK_HI 4
`define CSRS_BIT_BANK_LO 3
`define CSRS_BIT_OVF 2
`define CSRS_BIT_USER_B 1
`define CSRS_BIT_PARITY 0
// ==========================================================
// Arithmetic operation codes.
`define CSRS_OP_ADD 3'h0
`define CSRS_OP_ADDC 3'h1
`define CSRS_OP_SUBB 3'h2
`define CSRS_OP_MUL 3'h3
`define CSRS_OP_DIV 3'h4
`define CSRS_OP_OTHER 3'h5
`endif

// ---- csrs_stack_mem.sv ----
`timescale 1ns/10ps
// ====================
// Stack memory side.
module csrs_stack_mem (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire push_we_i,
  input wire [7:0] push_addr_i,
  output logic [7:0] last_addr_o,
  output logic [7:0] count_o
);
  // Logs where pushed bytes land, so the bench sees the real write address.
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      last_addr_o <= 8'h00;
      count_o <= 8'h00;
    end else if (push_we_i) begin
      last_addr_o <= push_addr_i;
      count_o <= count_o + 8'h01;
    end
  end
endmodule

// ---- tb_core_special_register_set.sv ----
`timescale 1ns/10ps
`include "csrs_regs.vh"
// ====================
// Bench.
module tb_core_special_register_set;
  logic sys_clk_i = 1'b0, rstn_i = 1'b0, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, sfr_bit_i = 1'b0;
  logic alu_go_i = 1'b0, push_i = 1'b0, ptr_ld_i = 1'b0;
  logic pop_i = 1'b0, ptr_inc_i = 1'b0, acc_ld_i = 1'b0;
  logic [7:0] sfr_addr_i = '0, sfr_wdata_i = '0, acc_ld_data_i = '0, a, b, p;
  logic [2:0] sfr_bit_sel_i = '0, alu_op_i = '0, reg_num_i = '0, op;
  logic [15:0] ptr_ld_data_i = '0;
  logic [23:0] e;
  wire [7:0] sfr_rdata_o, stack_top_index_o, push_addr_o, acc_o, opd_o, psw_o;
  wire [7:0] bank_o, last_a, n_push;
  wire [15:0] ptr_o;
  wire sfr_hit_o, push_we_o;
  int num_errors = 0, n_checks = 0, seed = 32640, i;
  logic [7:0] ra [6] = '{8'h81, 8'h82, 8'h83, 8'hD0, 8'hE0, 8'hF0};
  logic [7:0] rv [6] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // Clock at 25 MHz.
  always #20 sys_clk_i = ~sys_clk_i;

  // Every datapath strobe is driven, so pop, pointer step and load are reached too.
  csrs_core dut_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .sfr_wr_i(sfr_wr_i),
    .sfr_rd_i(sfr_rd_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_bit_i(sfr_bit_i), .sfr_bit_sel_i(sfr_bit_sel_i), .alu_go_i(alu_go_i),
    .alu_op_i(alu_op_i), .acc_ld_i(acc_ld_i), .acc_ld_data_i(acc_ld_data_i), .push_i(push_i),
    .pop_i(pop_i), .ptr_ld_i(ptr_ld_i), .ptr_ld_data_i(ptr_ld_data_i), .ptr_inc_i(ptr_inc_i),
    .reg_num_i(reg_num_i), .sfr_rdata_o(sfr_rdata_o), .sfr_hit_o(sfr_hit_o),
    .stack_top_index_o(stack_top_index_o), .push_addr_o(push_addr_o),
    .push_we_o(push_we_o), .indirect_pointer_word_o(ptr_o), .primary_accumulator_o(acc_o),
    .secondary_operand_o(opd_o), .program_status_word_o(psw_o), .bank_reg_addr_o(bank_o));
  csrs_stack_mem mem_u (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .push_we_i(push_we_o),
    .push_addr_i(push_addr_o), .last_addr_o(last_a), .count_o(n_push));

  // One request per edge: 0 idle, 1 write, 2 read, 3 bit write, 4 alu, 5 push, 6 pointer,
  // 7 pop, 8 pointer step, 9 accumulator load.
  task cyc(input [3:0] k, input [7:0] ad, input [7:0] d, input [2:0] s);
    @(posedge sys_clk_i);
    sfr_wr_i <= (k == 1) || (k == 3);
    sfr_rd_i <= (k == 2);
    sfr_bit_i <= (k == 3);
    alu_go_i <= (k == 4);
    push_i <= (k == 5);
    ptr_ld_i <= (k == 6);
    pop_i <= (k == 7);
    ptr_inc_i <= (k == 8);
    acc_ld_i <= (k == 9);
    sfr_addr_i <= ad;
    sfr_wdata_i <= d;
    acc_ld_data_i <= d;
    sfr_bit_sel_i <= s;
    alu_op_i <= s;
    reg_num_i <= s;
    ptr_ld_data_i <= {ad, d};
  endtask

  task chk(input [15:0] got, input [15:0] ex);
    n_checks++;
    if (got !== ex) begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, ex);
    end
  endtask

  // Read data lands one edge after the request is taken.
  task rd(input [7:0] ad, input [7:0] ex, input h);
    cyc(2, ad, 8'h00, 3'h0);
    cyc(0, 8'h00, 8'h00, 3'h0);
    #1;
    chk(sfr_rdata_o, ex);
    chk(sfr_hit_o, h);
  endtask

  // Expected {acc, operand, status}; multiply and divide clear both carries.
  function automatic [23:0] model(input [2:0] o, input [7:0] x, y, f);
    logic [8:0] s;
    logic [4:0] h;
    logic [15:0] m;
    logic [7:0] r, q;
    logic cy, ac, ov;
    r = x;
    q = y;
    cy = f[7];
    ac = f[6];
    ov = f[2];
    m = x * y;
    if (o <= 3'h1) begin
      s = {1'b0, x} + y + (o[0] & f[7]);
      h = x[3:0] + y[3:0] + (o[0] & f[7]);
      ov = (x[7] == y[7]) && (s[7] != x[7]);
    end else if (o == 3'h2) begin
      s = {1'b0, x} - y - f[7];
      h = {1'b0, x[3:0]} - y[3:0] - f[7];
      ov = (x[7] != y[7]) && (s[7] != x[7]);
    end
    if (o <= 3'h2) begin
      r = s[7:0];
      cy = s[8];
      ac = h[4];
    end else if (o <= 3'h4) begin
      cy = 1'b0;
      ac = 1'b0;
      ov = (o == 3'h3) ? (m > 255) : (y == 8'h00);
      if (o == 3'h3) {q, r} = m;
      else if (y != 8'h00) {r, q} = {x / y, x % y};
    end
    return {r, q, cy, ac, f[5:3], ov, f[1], ^r};
  endfunction

  task tally_and_finish;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog at several times the expected run length.
  initial begin
    repeat (4000) @(posedge sys_clk_i);
    num_errors++;
    tally_and_finish;
  end

  // Main sequence.
  initial begin
    repeat (2) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    for (i = 0; i < 6; i++) rd(ra[i], rv[i], 1'b1);
    cyc(1, 8'h84, 8'h00, 3'h0);
    rd(8'h84, 8'h00, 1'b0);
    cyc(1, 8'h81, 8'hFE, 3'h0);
    cyc(5, 8'h00, 8'h00, 3'h0);
    cyc(5, 8'h00, 8'h00, 3'h0);
    cyc(0, 8'h00, 8'h00, 3'h0);
    #1;
    chk(stack_top_index_o, 8'h00);
    // The stack model logs a push one edge after the core announces it.
    cyc(7, 8'h00, 8'h00, 3'h0);
    #1;
    chk({last_a, n_push}, 16'h0002);
    cyc(0, 8'h00, 8'h00, 3'h0);
    #1;
    chk(stack_top_index_o, 8'hFF);
    cyc(1, 8'h82, 8'h5A, 3'h0);
    cyc(1, 8'h83, 8'hC3, 3'h0);
    cyc(0, 8'h00, 8'h00, 3'h0);
    #1;
    chk(ptr_o, 16'hC35A);
    cyc(6, 8'h12, 8'hFF, 3'h0);
    rd(8'h83, 8'h12, 1'b1);
    cyc(8, 8'h00, 8'h00, 3'h0);
    cyc(0, 8'h00, 8'h00, 3'h0);
    #1;
    chk(ptr_o, 16'h1300);
    // Bit writes: parity is read-only, elsewhere a bit write is a byte write.
    cyc(3, 8'hE0, 8'h01, 3'h3);
    cyc(3, 8'hF0, 8'h01, 3'h7);
    cyc(3, 8'hD0, 8'h01, 3'h0);
    cyc(3, 8'hD0, 8'h01, 3'h5);
    cyc(3, 8'h81, 8'h41, 3'h2);
    rd(8'hE0, 8'h08, 1'b1);
    rd(8'hF0, 8'h80, 1'b1);
    rd(8'hD0, 8'h21, 1'b1);
    rd(8'h81, 8'h41, 1'b1);
    cyc(9, 8'h00, 8'h03, 3'h0);
    cyc(0, 8'h00, 8'h00, 3'h0);
    #1;
    chk({acc_o, psw_o}, 16'h0320);
    for (i = 0; i < 4; i++) begin
      cyc(1, 8'hD0, 8'(i * 8), 3'(i + 3));
      cyc(0, 8'h00, 8'h00, 3'(i + 3));
      #1;
      chk(bank_o, 16'(9 * i + 3));
    end
    // Random operands with carry, divide-by-zero and full-product corners.
    for (i = 0; i < 48; i++) begin
      a = 8'($random(seed));
      b = 8'($random(seed));
      p = 8'($random(seed));
      op = 3'(i % 6);
      if (i % 12 == 4) b = 8'h00;
      if (i % 12 == 3) {a, b} = 16'hFFFF;
      if (i == 0) {a, b} = 16'h8080;
      cyc(1, 8'hE0, a, 3'h0);
      cyc(1, 8'hF0, b, 3'h0);
      cyc(1, 8'hD0, p, 3'h0);
      cyc(4, 8'h00, 8'h00, op);
      e = model(op, a, b, p);
      rd(8'hE0, e[23:16], 1'b1);
      rd(8'hF0, e[15:8], 1'b1);
      rd(8'hD0, e[7:0], 1'b1);
    end
    tally_and_finish;
  end
endmodule
